// ==== design/cfm_fault_mgr.sv ====
`timescale 1ns/1ps
module cfm_fault_mgr #(
  parameter int LINE_MASK = cfm_pkg::LINE_MASK_CYCLES,
  parameter int UNPLUG  = cfm_pkg::UNPLUG_CYCLES,
  parameter int DC_DET  = cfm_pkg::DC_DETECT_CYCLES,
  parameter int STABLE  = cfm_pkg::STABLE_CYCLES,
  parameter int UNDERV_CYC = cfm_pkg::UNDERV_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  // Analog comparator levels, then cycle, gate and status-clear controls
  input  wire cfm_pkg::cfm_pri_t        pri_i,
  input  wire cfm_pkg::cfm_sec_t        sec_i,
  input  wire logic                     blank_done_i,
  input  wire logic                     cycle_start_i,
  input  wire logic                     gate_req_i,
  input  wire logic                     status_clr_i,
  // Power stage outputs
  output logic                          switch_en_o,
  output logic                          lowside_gate_drive_o,
  output logic                          burst_o,
  output logic                          xcap_discharge_o,
  output logic                          load_switch_on_o,
  output logic                          hard_reset_o,
  output logic                          warn_temp_o,
  output logic                          power_good_output_o,
  output logic [cfm_pkg::NFLT-1:0]      status_o
);
  import cfm_pkg::*;

  initial
  begin
    if (LINE_MASK < 1 || UNPLUG < 1 || DC_DET < 1 || STABLE < 1 || UNDERV_CYC < 1)
      $error("cfm_fault_mgr: counts must be positive");
  end

  // Comparators are asynchronous to clk
  cfm_pri_t pri_m_q, pri_s_q;
  cfm_sec_t sec_m_q, sec_s_q;
  always_ff @(posedge clk_i)
  begin
    pri_m_q <= pri_i;
    pri_s_q <= pri_m_q;
    sec_m_q <= sec_i;
    sec_s_q <= sec_m_q;
  end

  logic supply_d1_q;
  logic supply_rise;
  assign supply_rise = pri_s_q.supply_above_turnoff & ~supply_d1_q;
  always_ff @(posedge clk_i)
    supply_d1_q <= pri_s_q.supply_above_turnoff;

  // Brown-in / brown-out gating
  logic        line_ok_q;
  logic [31:0] lmask_cnt_q;
  logic        line_low_evt;
  assign line_low_evt = line_ok_q && lmask_cnt_q >= 32'(LINE_MASK);
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      line_ok_q   <= 1'b0;
      lmask_cnt_q <= '0;
    end
    else
    begin
      if (!pri_s_q.line_below_brownout)
        lmask_cnt_q <= '0;
      else if (!line_low_evt)
        lmask_cnt_q <= lmask_cnt_q + 32'd1;
      if (pri_s_q.line_above_brownin)
        line_ok_q <= 1'b1;
      else if (line_low_evt)
        line_ok_q <= 1'b0;
    end
  end

  // Unplug detect: no AC edge for a long time, DC included
  logic [31:0] dc_cnt_q;
  logic [31:0] xd_cnt_q;
  logic        unplug;
  logic        xcap_evt;
  assign unplug   = dc_cnt_q >= 32'(DC_DET);
  assign xcap_evt = unplug && xd_cnt_q == 32'(UNPLUG) - 32'd1 && !xcap_discharge_o;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      dc_cnt_q         <= '0;
      xd_cnt_q         <= '0;
      xcap_discharge_o <= 1'b0;
    end
    else
    begin
      if (pri_s_q.line_ac_edge)
        dc_cnt_q <= '0;
      else if (!unplug)
        dc_cnt_q <= dc_cnt_q + 32'd1;
      if (!unplug || xcap_discharge_o)
        xd_cnt_q <= '0;
      else
        xd_cnt_q <= xd_cnt_q + 32'd1;
      if (xcap_evt)
        xcap_discharge_o <= 1'b1;
      else if (pri_s_q.line_below_min || pri_s_q.line_ac_edge)
        xcap_discharge_o <= 1'b0;
    end
  end

  // Second-level overcurrent: idle / warning
  // Trips gather per cycle and clear at its start, so none leaks into the next
  logic warn_q, trip_seen_q, trip_cyc, ocur_evt;
  assign trip_cyc = trip_seen_q | pri_s_q.current_over_second;
  assign ocur_evt = warn_q && cycle_start_i && trip_cyc;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      warn_q      <= 1'b0;
      trip_seen_q <= 1'b0;
    end
    else if (cycle_start_i)
    begin
      trip_seen_q <= 1'b0;
      if (warn_q)
        warn_q <= 1'b0;
      else if (trip_cyc)
        warn_q <= 1'b1;
    end
    else if (pri_s_q.current_over_second)
      trip_seen_q <= 1'b1;
  end

  // Secondary undervoltage persistence
  logic [31:0] underv_cnt_q;
  logic        underv_evt;
  assign underv_evt = underv_cnt_q == 32'(UNDERV_CYC) - 32'd1 && sec_s_q.sec_undervoltage;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !sec_s_q.sec_undervoltage)
      underv_cnt_q <= '0;
    else if (underv_cnt_q < 32'(UNDERV_CYC))
      underv_cnt_q <= underv_cnt_q + 32'd1;
  end

  // Fault event vector
  logic [NFLT-1:0] evt;
  logic            ss_evt;
  assign ss_evt = pri_s_q.softstart_at_end && !sec_s_q.secondary_active;
  always_comb
  begin
    evt          = '0;
    evt[F_SUPPLY_LOW] = !pri_s_q.supply_above_turnoff;
    evt[F_POVP]  = pri_s_q.primary_overvoltage;
    evt[F_POCP]  = ocur_evt;
    evt[F_SS_TIMEOUT] = ss_evt;
    evt[F_POT]   = pri_s_q.thermistor_low;
    evt[F_LINE_LOW] = line_low_evt;
    evt[F_XCAP]  = xcap_evt;
    evt[F_SOCP]  = sec_s_q.sec_overcurrent;
    evt[F_SOVP]  = sec_s_q.sec_overvoltage;
    evt[F_SUVP]  = underv_evt;
    evt[F_SUVLO] = sec_s_q.sec_lockout;
    evt[F_SEC_TEMP] = sec_s_q.sec_temp_trip;
    evt[F_SWTP]  = sec_s_q.warn_enable && sec_s_q.sec_temp_warn;
    evt[F_LAST]  = sec_s_q.sec_last_fault;
  end

  // Sticky flags; a new event wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      status_o <= '0;
    else
      status_o <= (status_clr_i ? '0 : status_o) | evt;
  end

  logic auto_evt, cond_evt, cond_hold;
  assign auto_evt  = evt[F_SUPPLY_LOW] | evt[F_POCP] | evt[F_SS_TIMEOUT] | evt[F_SUVP]
                   | evt[F_SUVLO] | evt[F_SEC_TEMP];
  assign cond_evt  = evt[F_POT] | line_low_evt | xcap_evt;
  assign cond_hold = pri_s_q.thermistor_low | !line_ok_q | unplug;

  // Restart supervision
  cfm_mode_t mode_q;
  logic [2:0] rcnt_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_q <= CFM_RUN;
      rcnt_q <= '0;
    end
    else
    begin
      case (mode_q)
        CFM_RUN:
        begin
          rcnt_q <= '0;
          if (cond_evt)
            mode_q <= CFM_COND;
          else if (auto_evt)
            mode_q <= CFM_AUTO;
          else if (evt[F_POVP] || evt[F_SOVP])
            mode_q <= CFM_BURST;
        end
        CFM_BURST:
        begin
          if (cond_evt)
            mode_q <= CFM_COND;
          else if (auto_evt)
            mode_q <= CFM_AUTO;
          else if (!pri_s_q.primary_overvoltage && !sec_s_q.sec_overvoltage
                   && sec_s_q.sec_out_safe)
            mode_q <= CFM_RUN;
        end
        CFM_AUTO:
        begin
          if (cond_evt)
          begin
            mode_q <= CFM_COND;
            rcnt_q <= '0;
          end
          else if (supply_rise)
          begin
            if (rcnt_q == 3'(AR_CYCLES - 1))
              mode_q <= CFM_RUN;
            rcnt_q <= rcnt_q + 3'd1;
          end
        end
        default:
        begin
          if (cond_hold)
            rcnt_q <= '0;
          else if (supply_rise)
            mode_q <= CFM_RUN;
        end
      endcase
    end
  end

  // Switching enable and gate drive
  logic run_ok;
  assign run_ok = mode_q == CFM_RUN && line_ok_q && !cond_evt && !auto_evt
               && !xcap_discharge_o;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      switch_en_o          <= 1'b0;
      burst_o              <= 1'b0;
      lowside_gate_drive_o <= 1'b0;
    end
    else
    begin
      switch_en_o <= run_ok;
      burst_o     <= mode_q == CFM_BURST;
      if (!run_ok || !gate_req_i)
        lowside_gate_drive_o <= 1'b0;
      else if (blank_done_i && pri_s_q.current_over_clamp)
        lowside_gate_drive_o <= 1'b0;
      else if (cycle_start_i)
        lowside_gate_drive_o <= 1'b1;
    end
  end

  // Load switch, hard reset, warning
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      load_switch_on_o <= 1'b0;
      hard_reset_o     <= 1'b0;
      warn_temp_o      <= 1'b0;
    end
    else
    begin
      hard_reset_o <= evt[F_LAST];
      warn_temp_o  <= evt[F_SWTP];
      if ((evt[F_SOCP] && sec_s_q.loadsw_fitted) || evt[F_LAST])
        load_switch_on_o <= 1'b0;
      else
        load_switch_on_o <= power_good_output_o;
    end
  end

  // Power good after soft-start and stable run
  logic [31:0] pg_cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !run_ok || !sec_s_q.secondary_active)
    begin
      pg_cnt_q            <= '0;
      power_good_output_o <= 1'b0;
    end
    else if (pg_cnt_q < 32'(STABLE))
      pg_cnt_q <= pg_cnt_q + 32'd1;
    else
      power_good_output_o <= 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_gate_clamp_off: assert property (blank_done_i && pri_s_q.current_over_clamp |=> !lowside_gate_drive_o) else $error("gate not dropped");
  a_no_brownin_run: assert property (!line_ok_q |=> !switch_en_o) else $error("switching before brown-in");
  a_line_low_stops: assert property (line_low_evt |=> !switch_en_o) else $error("brown-out did not stop");
  a_ocur_confirm: assert property (ocur_evt |=> mode_q == CFM_AUTO || mode_q == CFM_COND) else $error("overcurrent not auto-restart");
  a_warn_clears: assert property (warn_q && cycle_start_i |=> !warn_q) else $error("warning state stuck");
  a_therm_cond: assert property (mode_q == CFM_RUN && pri_s_q.thermistor_low |=> mode_q == CFM_COND) else $error("thermistor not handled");
  a_supply_low_auto: assert property (mode_q == CFM_RUN && !pri_s_q.supply_above_turnoff && !cond_evt |=> mode_q == CFM_AUTO) else $error("supply low not auto");
  a_sticky_flag: assert property (evt[F_LINE_LOW] |=> status_o[F_LINE_LOW]) else $error("flag lost");
  a_hard_reset: assert property (evt[F_LAST] |=> hard_reset_o && !load_switch_on_o) else $error("hard reset missing");
  a_pg_needs_run: assert property (!run_ok |=> !power_good_output_o) else $error("power good early");
  a_discharge_go: assert property (xcap_evt |=> xcap_discharge_o) else $error("discharge not started");

  c_ocur_warn: cover property (warn_q && cycle_start_i && !trip_cyc);
  c_auto_restart: cover property (mode_q == CFM_AUTO ##1 mode_q == CFM_RUN);
  c_discharge: cover property (xcap_discharge_o ##1 !xcap_discharge_o);
  c_power_good: cover property ($rose(power_good_output_o));
endmodule : cfm_fault_mgr

// ==== design/cfm_pkg.sv ====
package cfm_pkg;
  localparam int CLK_HZ          = 25000000;
  localparam int UNDERV_TIME_NS  = 480000;
  localparam int UNDERV_CYCLES   = (UNDERV_TIME_NS / 1000) * (CLK_HZ / 1000000);
  localparam int LINE_MASK_CYCLES = 1250;
  localparam int UNPLUG_CYCLES   = 2500;
  localparam int DC_DETECT_CYCLES = 250000;
  localparam int STABLE_CYCLES   = 2500;
  localparam int AR_CYCLES       = 6;
  localparam int CR_CYCLES       = 1;
  localparam int NFLT            = 14;

  // Sticky status bit positions
  localparam int F_SUPPLY_LOW = 0;
  localparam int F_POVP  = 1;
  localparam int F_POCP  = 2;
  localparam int F_SS_TIMEOUT = 3;
  localparam int F_POT   = 4;
  localparam int F_LINE_LOW = 5;
  localparam int F_XCAP  = 6;
  localparam int F_SOCP  = 7;
  localparam int F_SOVP  = 8;
  localparam int F_SUVP  = 9;
  localparam int F_SUVLO = 10;
  localparam int F_SEC_TEMP = 11;
  localparam int F_SWTP  = 12;
  localparam int F_LAST  = 13;

  typedef enum logic [1:0] {
    CFM_RUN,
    CFM_AUTO,
    CFM_COND,
    CFM_BURST
  } cfm_mode_t;

  typedef struct packed {
    logic line_above_brownin;
    logic line_below_brownout;
    logic line_below_min;
    logic line_ac_edge;
    logic current_over_clamp;
    logic current_over_second;
    logic thermistor_low;
    logic supply_above_turnoff;
    logic primary_overvoltage;
    logic softstart_at_end;
  } cfm_pri_t;

  typedef struct packed {
    logic secondary_active;
    logic loadsw_fitted;
    logic sec_overcurrent;
    logic sec_overvoltage;
    logic sec_out_safe;
    logic sec_undervoltage;
    logic sec_lockout;
    logic sec_temp_warn;
    logic sec_temp_trip;
    logic warn_enable;
    logic sec_last_fault;
  } cfm_sec_t;
endpackage : cfm_pkg

// ==== dv/cfm_fault_mgr_bench.sv ====
`timescale 1ns/1ps
module cfm_fault_mgr_bench;
  import cfm_pkg::*;
  localparam int BOM = 8;
  localparam int UNP = 10;
  localparam int DCD = 20;
  localparam int STB = 10;
  logic            clk_i     = 1'b0;
  logic            sys_rst_i = 1'b1;
  cfm_pri_t        pri_q     = 10'h000;
  cfm_sec_t        sec_q     = 11'h640;
  cfm_pri_t        pri_w;
  logic            blank_q   = 1'b0;
  logic            cyc_q     = 1'b0;
  logic            gate_q    = 1'b0;
  logic            clr_q     = 1'b0;
  logic            plug_q    = 1'b1;
  logic            dip_q     = 1'b0;
  logic            ac_edge;
  logic            sup_ok;
  logic            sw_en;
  logic            lgd;
  logic            xcap_discharge_fault;
  logic            lsw;
  logic            hrst;
  logic            pgood;
  logic [NFLT-1:0] status;
  int              failures  = 0;
  int              cmp_count = 0;

  always_comb
  begin
    pri_w = pri_q;
    pri_w.line_ac_edge = ac_edge;
    pri_w.supply_above_turnoff = sup_ok;
  end

  cfm_partner ptn_u (.clk_i(clk_i), .plugged_i(plug_q), .dip_i(dip_q),
    .ac_edge_o(ac_edge), .supply_ok_o(sup_ok));

  cfm_fault_mgr #(.LINE_MASK(BOM), .UNPLUG(UNP), .DC_DET(DCD), .STABLE(STB), .UNDERV_CYC(12))
    dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pri_i(pri_w), .sec_i(sec_q),
    .blank_done_i(blank_q), .cycle_start_i(cyc_q), .gate_req_i(gate_q),
    .status_clr_i(clr_q), .switch_en_o(sw_en), .lowside_gate_drive_o(lgd), .burst_o(),
    .xcap_discharge_o(xcap_discharge_fault), .load_switch_on_o(lsw), .hard_reset_o(hrst), .warn_temp_o(),
    .power_good_output_o(pgood), .status_o(status));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk

  // Outputs are looked at mid-cycle, clear of the launching edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic wait_sw(input logic v, input int lim);
    int i;
    i = 0;
    while (sw_en !== v && i < lim)
    begin
      @(negedge clk_i);
      i++;
    end
    chk("switch_en_o", v, sw_en);
  endtask : wait_sw

  task automatic kick(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      dip_q <= 1'b1;
      @(posedge clk_i);
      dip_q <= 1'b0;
      repeat (10) @(posedge clk_i);
    end
  endtask : kick

  task automatic line(input logic ok);
    @(posedge clk_i);
    pri_q.line_above_brownin  <= ok;
    pri_q.line_below_brownout <= !ok;
  endtask : line

  task automatic ocyc(input logic trip);
    @(posedge clk_i);
    pri_q.current_over_second <= trip;
    repeat (2) @(posedge clk_i);
    pri_q.current_over_second <= 1'b0;
    repeat (4) @(posedge clk_i);
    cyc_q <= 1'b1;
    @(posedge clk_i);
    cyc_q <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : ocyc

  task automatic t_start;
    settle(10);
    chk("switch_en_o", 1'b0, sw_en);
    line(1'b1);
    wait_sw(1'b1, 20);
    chk("power_good_output_o", 1'b0, pgood);
    settle(STB + 6);
    chk("power_good_output_o", 1'b1, pgood);
    chk("load_switch_on_o", 1'b1, lsw);
  endtask : t_start

  task automatic t_clamp;
    @(posedge clk_i);
    gate_q <= 1'b1;
    pri_q.current_over_clamp <= 1'b1;
    @(posedge clk_i);
    cyc_q <= 1'b1;
    @(posedge clk_i);
    cyc_q <= 1'b0;
    settle(5);
    chk("lowside_gate_drive_o", 1'b1, lgd);
    @(posedge clk_i);
    blank_q <= 1'b1;
    settle(5);
    chk("lowside_gate_drive_o", 1'b0, lgd);
    chk("switch_en_o", 1'b1, sw_en);
    @(posedge clk_i);
    pri_q.current_over_clamp <= 1'b0;
    repeat (3) @(posedge clk_i);
    cyc_q <= 1'b1;
    @(posedge clk_i);
    cyc_q <= 1'b0;
    settle(5);
    chk("lowside_gate_drive_o", 1'b1, lgd);
  endtask : t_clamp

  task automatic t_bo;
    line(1'b0);
    repeat (BOM - 3) @(posedge clk_i);
    line(1'b1);
    settle(6);
    chk("switch_en_o", 1'b1, sw_en);
    line(1'b0);
    settle(BOM + 8);
    chk("switch_en_o", 1'b0, sw_en);
    chk("status_o line low", 1'b1, status[F_LINE_LOW]);
    line(1'b1);
    kick(1);
    wait_sw(1'b1, 20);
  endtask : t_bo

  task automatic t_ocp;
    ocyc(1'b1);
    ocyc(1'b0);
    ocyc(1'b0);
    chk("switch_en_o", 1'b1, sw_en);
    ocyc(1'b1);
    ocyc(1'b1);
    ocyc(1'b0);
    chk("switch_en_o", 1'b0, sw_en);
    chk("status_o overcurrent", 1'b1, status[F_POCP]);
    kick(AR_CYCLES - 1);
    settle(2);
    chk("switch_en_o", 1'b0, sw_en);
    kick(1);
    wait_sw(1'b1, 20);
  endtask : t_ocp

  task automatic t_otp;
    @(posedge clk_i);
    pri_q.thermistor_low <= 1'b1;
    settle(5);
    chk("switch_en_o", 1'b0, sw_en);
    chk("status_o overtemp", 1'b1, status[F_POT]);
    kick(1);
    chk("switch_en_o", 1'b0, sw_en);
    @(posedge clk_i);
    pri_q.thermistor_low <= 1'b0;
    kick(1);
    wait_sw(1'b1, 20);
  endtask : t_otp

  task automatic t_sec;
    @(posedge clk_i);
    sec_q.sec_overcurrent <= 1'b1;
    settle(5);
    chk("load_switch_on_o", 1'b0, lsw);
    @(posedge clk_i);
    sec_q.sec_overcurrent <= 1'b0;
    sec_q.sec_last_fault <= 1'b1;
    settle(5);
    chk("hard_reset_o", 1'b1, hrst);
    chk("load_switch_on_o", 1'b0, lsw);
    chk("switch_en_o", 1'b1, sw_en);
    @(posedge clk_i);
    sec_q.sec_last_fault <= 1'b0;
    settle(5);
    chk("hard_reset_o", 1'b0, hrst);
  endtask : t_sec

  task automatic t_unplug;
    @(posedge clk_i);
    plug_q <= 1'b0;
    settle(DCD - 4);
    chk("xcap_discharge_o", 1'b0, xcap_discharge_fault);
    settle(UNP + 16);
    chk("xcap_discharge_o", 1'b1, xcap_discharge_fault);
    @(posedge clk_i);
    pri_q.line_below_min <= 1'b1;
    clr_q <= 1'b1;
    @(posedge clk_i);
    clr_q <= 1'b0;
    settle(5);
    chk("xcap_discharge_o", 1'b0, xcap_discharge_fault);
    chk("status_o overtemp", 1'b0, status[F_POT]);
  endtask : t_unplug

  initial
  begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_start;
    t_clamp;
    t_bo;
    t_ocp;
    t_otp;
    t_sec;
    t_unplug;
    conclude;
  end

  // Whole run needs some four hundred cycles
  initial
  begin
    #(40 * 20000);
    failures++;
    conclude;
  end
endmodule : cfm_fault_mgr_bench

// ==== dv/cfm_partner.sv ====
`timescale 1ns/1ps
module cfm_partner (
  // Clock
  input  wire logic clk_i,
  // Bench control
  input  wire logic plugged_i,
  input  wire logic dip_i,
  // Comparator levels
  output logic      ac_edge_o,
  output logic      supply_ok_o
);
  logic [2:0] ph_q  = 3'h0;
  logic [1:0] dip_q = 2'h0;
  logic       edge_q = 1'b0;
  logic       ok_q  = 1'b1;

  assign ac_edge_o   = edge_q;
  assign supply_ok_o = ok_q;

  // Line events stop when unplugged, as a steady DC level would look
  always_ff @(posedge clk_i)
  begin
    ph_q      <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    edge_q <= plugged_i && (ph_q == 3'h0);
  end

  // Each dip request drops the supply below turn-off, then it recovers
  always_ff @(posedge clk_i)
  begin
    dip_q       <= dip_i ? 2'h3 : (dip_q != 2'h0) ? dip_q - 2'h1 : 2'h0;
    ok_q  <= !dip_i && (dip_q == 2'h0);
  end
endmodule : cfm_partner
